// ### rtl/hw_break_defs.svh
// offsets, field positions, reset values and the summary of operation for the breakpoint unit
// Summary of operation
// - build option selects none, two instruction plus one data, or four plus two breakpoints.
// - instruction breakpoints 0 to 3, data 0 and 1, each with its own registers.
// - no comparison while the core runs in debug mode.
// - a hit raises an exception, a trigger or both, per control enable bits.
// - every hit sets that breakpoint's status flag.
// - instruction compare covers every executed instruction, address errors included; the unit does not compare unaligned pcs.
// - speculative or unaligned instruction addresses are never compared.
// - instruction hit needs id compare off or equal, and every unmasked PC bit equal.
// - instruction hits are reported on the very instruction that matched.
// - data compare covers every executed load or store, coprocessor and faulting ones too.
// - hints and non-explicit transactions are never compared.
// - data hit needs allowed type, address condition, and value condition or no compare.
// - accessed lanes bit n marks byte n of the data bus as accessed.
// - address condition: id check, masked address equal, some accessed lane not ignored.
// - value compare skipped when every lane is value-masked, ignored or not accessed.
// - value holds when every lane's byte equals or is unaccessed, masked or ignored.
// - data hits are evaluated and reported with the executing load or store.
// - hardware only sets status flags; only software clears them.
// - a store that takes a data break exception is blocked from writing memory.
`ifndef HW_BREAK_DEFS_SVH
`define HW_BREAK_DEFS_SVH

// register map, status and bank offsets in bytes, slot fields as word numbers
`define OFS_INSTR_STATUS     8'h00
`define OFS_DATA_STATUS      8'h04
`define OFS_INSTR_BASE       8'h40
`define OFS_DATA_BASE        8'hC0
`define OFS_STRIDE           8'h20
`define OFS_ADDR             3'h0
`define OFS_MASK             3'h1
`define OFS_SPACE            3'h2
`define OFS_CTRL             3'h3
`define OFS_VALUE            3'h4

// control field positions
`define CTRL_EXC_BIT         0
`define CTRL_TRIG_BIT        1
`define CTRL_SPACE_BIT       2
`define CTRL_SKIP_LOAD_BIT   3
`define CTRL_SKIP_STORE_BIT  4
`define CTRL_IGNORE_LO       8
`define CTRL_VMASK_LO        12

// reset values
`define CTRL_RESET           32'h0000_0000
`define MASK_RESET           32'h0000_0000

`endif

// ### rtl/hw_break_pkg.sv
// types for the breakpoint unit
package hw_break_pkg;
  typedef enum logic [1:0] {
    CFG_NONE,
    CFG_SMALL,
    CFG_FULL
  } bp_config_t;

  typedef enum {
    XACT_IDLE,
    XACT_HELD
  } store_state_t;
endpackage : hw_break_pkg

// ### rtl/data_break_cmp.sv
// one data breakpoint comparator, purely combinational
`include "hw_break_defs.svh"
module data_break_cmp (
  input  wire logic [31:0] addr,
  input  wire logic [7:0]  space_id,
  input  wire logic [3:0]  accessed_lanes,
  input  wire logic [31:0] data,
  input  wire logic        is_load,
  input  wire logic        is_store,
  input  wire logic [31:0] data_break_addr,
  input  wire logic [31:0] data_break_addr_mask,
  input  wire logic [7:0]  data_break_space_id,
  input  wire logic [31:0] data_break_ctrl,
  input  wire logic [31:0] data_break_value,
  output logic             data_hit,
  output logic             value_check_skipped
);
  logic [3:0] lane_ignore;
  logic [3:0] lane_value_mask;
  logic [3:0] lane_ok;
  logic       data_addr_hit;
  logic       value_hit;
  logic       type_ok;

  assign lane_ignore     = data_break_ctrl[`CTRL_IGNORE_LO +: 4];
  assign lane_value_mask = data_break_ctrl[`CTRL_VMASK_LO +: 4];

  // address part with lane qualification
  assign data_addr_hit = (!data_break_ctrl[`CTRL_SPACE_BIT] || (space_id == data_break_space_id)) &&
                         (&(data_break_addr_mask | ~(addr ^ data_break_addr))) &&
                         ((~lane_ignore & accessed_lanes) != 4'h0);
  assign value_check_skipped = &(lane_value_mask | lane_ignore | ~accessed_lanes);

  // per-lane byte compare on raw bus order
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      lane_ok[i] = (data[8*i +: 8] == data_break_value[8*i +: 8]) || !accessed_lanes[i] ||
                   lane_value_mask[i] || lane_ignore[i];
    end
  end
  assign value_hit = &lane_ok;

  // transaction type gate and final combination
  assign type_ok  = (is_load && !data_break_ctrl[`CTRL_SKIP_LOAD_BIT]) ||
                    (is_store && !data_break_ctrl[`CTRL_SKIP_STORE_BIT]);
  assign data_hit = type_ok && data_addr_hit && (value_check_skipped || value_hit);
endmodule : data_break_cmp

// ### rtl/hw_break_match.sv
// hardware breakpoint comparison unit with register port and pipeline-facing result flops
`include "hw_break_defs.svh"
module hw_break_match #(
  parameter hw_break_pkg::bp_config_t CONFIG = hw_break_pkg::CFG_FULL
) (
  input  wire logic        clk,
  input  wire logic        reset_n,
  // register port
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_write,
  input  wire logic        reg_read,
  output logic      [31:0] reg_rdata,
  // core state
  input  wire logic        debug_mode,
  input  wire logic [7:0]  address_space_id,
  // instruction stage
  input  wire logic        instr_valid,
  input  wire logic        instr_speculative,
  input  wire logic        instr_aligned,
  input  wire logic [31:0] instr_pc,
  // data stage
  input  wire logic        data_valid,
  input  wire logic        data_is_load,
  input  wire logic        data_is_store,
  input  wire logic        data_explicit,
  input  wire logic [31:0] data_addr,
  input  wire logic [3:0]  accessed_lanes,
  input  wire logic [31:0] data_bus,
  // results, registered with the stage
  output logic             instr_break_exc,
  output logic             instr_trigger,
  output logic             data_break_exc,
  output logic             data_trigger,
  output logic             store_block
);
  // implemented breakpoint counts per build option
  localparam int NUM_I = (CONFIG == hw_break_pkg::CFG_FULL) ? 4 : (CONFIG == hw_break_pkg::CFG_SMALL) ? 2 : 0;
  localparam int NUM_D = (CONFIG == hw_break_pkg::CFG_FULL) ? 2 : (CONFIG == hw_break_pkg::CFG_SMALL) ? 1 : 0;

  logic        rst_meta_q;
  logic        rst_sync_q;
  logic        rst_n;

  logic [31:0] instr_break_addr      [4];
  logic [31:0] instr_break_addr_mask [4];
  logic [7:0]  instr_break_space_id  [4];
  logic [31:0] instr_break_ctrl      [4];
  logic [31:0] data_break_addr       [2];
  logic [31:0] data_break_addr_mask  [2];
  logic [7:0]  data_break_space_id   [2];
  logic [31:0] data_break_ctrl       [2];
  logic [31:0] data_break_value      [2];
  logic [3:0]  instr_hit_flags_q;
  logic [1:0]  data_hit_flags_q;

  logic [3:0]  instr_hit;
  logic [1:0]  data_hit;
  logic        instr_eval;
  logic        data_eval;
  logic [31:0] rdata_d;

  // decodes a register word: returns the slot field when the address lands in a bank
  function automatic logic bank_hit(input logic [7:0] a, input logic [7:0] base, input int n,
                                    output int idx, output logic [2:0] field);
    logic [7:0] off;
    off   = a - base;
    idx   = int'(off[7:5]);
    field = off[4:2];
    return (a >= base) && (idx < n) && (off[1:0] == 2'h0);
  endfunction : bank_hit

  // reset release through two flops
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end
  assign rst_n = rst_sync_q;

  // comparison gating: never in debug mode, only real executed work
  assign instr_eval = instr_valid && !debug_mode && !instr_speculative && instr_aligned;
  assign data_eval  = data_valid && !debug_mode && data_explicit && (data_is_load || data_is_store);

  // every address bit either masked out or equal to the stored one
  function automatic logic masked_equal(input logic [31:0] a, input logic [31:0] b, input logic [31:0] m);
    return &(m | ~(a ^ b));
  endfunction : masked_equal

  // instruction comparators: enable bits grouped on their own so exception-only slots still hit
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      instr_hit[i] = (i < NUM_I) && instr_eval &&
                     (instr_break_ctrl[i][`CTRL_EXC_BIT] || instr_break_ctrl[i][`CTRL_TRIG_BIT]) &&
                     (!instr_break_ctrl[i][`CTRL_SPACE_BIT] || (address_space_id == instr_break_space_id[i])) &&
                     masked_equal(instr_pc, instr_break_addr[i], instr_break_addr_mask[i]);
    end
  end

  // data comparators
  for (genvar g = 0; g < 2; g++) begin : g_dcmp
    logic raw_hit;
    data_break_cmp u_cmp (
      .addr                 (data_addr),
      .space_id             (address_space_id),
      .accessed_lanes       (accessed_lanes),
      .data                 (data_bus),
      .is_load              (data_is_load),
      .is_store             (data_is_store),
      .data_break_addr      (data_break_addr[g]),
      .data_break_addr_mask (data_break_addr_mask[g]),
      .data_break_space_id  (data_break_space_id[g]),
      .data_break_ctrl      (data_break_ctrl[g]),
      .data_break_value     (data_break_value[g]),
      .data_hit             (raw_hit),
      .value_check_skipped  ()
    );
    assign data_hit[g] = (g < NUM_D) && data_eval && raw_hit &&
                         (data_break_ctrl[g][`CTRL_EXC_BIT] || data_break_ctrl[g][`CTRL_TRIG_BIT]);
  end

  // software-written breakpoint registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < 4; i++) begin
        instr_break_addr[i]      <= 32'h0000_0000;
        instr_break_addr_mask[i] <= `MASK_RESET;
        instr_break_space_id[i]  <= 8'h00;
        instr_break_ctrl[i]      <= `CTRL_RESET;
      end
      for (int j = 0; j < 2; j++) begin
        data_break_addr[j]      <= 32'h0000_0000;
        data_break_addr_mask[j] <= `MASK_RESET;
        data_break_space_id[j]  <= 8'h00;
        data_break_ctrl[j]      <= `CTRL_RESET;
        data_break_value[j]     <= 32'h0000_0000;
      end
    end else if (reg_write) begin
      int         idx;
      logic [2:0] fld;
      if (bank_hit(reg_addr, `OFS_INSTR_BASE, NUM_I, idx, fld)) begin
        case (fld)
          `OFS_ADDR:  instr_break_addr[idx]      <= reg_wdata;
          `OFS_MASK:  instr_break_addr_mask[idx] <= reg_wdata;
          `OFS_SPACE: instr_break_space_id[idx]  <= reg_wdata[7:0];
          `OFS_CTRL:  instr_break_ctrl[idx]      <= reg_wdata;
          default: ;
        endcase
      end else if (bank_hit(reg_addr, `OFS_DATA_BASE, NUM_D, idx, fld)) begin
        case (fld)
          `OFS_ADDR:  data_break_addr[idx]      <= reg_wdata;
          `OFS_MASK:  data_break_addr_mask[idx] <= reg_wdata;
          `OFS_SPACE: data_break_space_id[idx]  <= reg_wdata[7:0];
          `OFS_CTRL:  data_break_ctrl[idx]      <= reg_wdata;
          `OFS_VALUE: data_break_value[idx]     <= reg_wdata;
          default: ;
        endcase
      end
    end
  end

  // sticky hit flags: hardware sets, software writes one to clear, set wins
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      instr_hit_flags_q <= 4'h0;
      data_hit_flags_q  <= 2'h0;
    end else begin
      instr_hit_flags_q <= (instr_hit_flags_q &
                            ~((reg_write && reg_addr == `OFS_INSTR_STATUS) ? reg_wdata[3:0] : 4'h0)) |
                           instr_hit;
      data_hit_flags_q  <= (data_hit_flags_q &
                            ~((reg_write && reg_addr == `OFS_DATA_STATUS) ? reg_wdata[1:0] : 2'h0)) |
                           data_hit;
    end
  end

  // read mux, unmapped words read zero
  always_comb begin
    int         idx;
    logic [2:0] fld;
    idx     = 0;
    fld     = 3'h0;
    rdata_d = 32'h0000_0000;
    if (reg_addr == `OFS_INSTR_STATUS) begin
      rdata_d = {28'h0000000, instr_hit_flags_q};
    end else if (reg_addr == `OFS_DATA_STATUS) begin
      rdata_d = {30'h00000000, data_hit_flags_q};
    end else if (bank_hit(reg_addr, `OFS_INSTR_BASE, NUM_I, idx, fld)) begin
      case (fld)
        `OFS_ADDR:  rdata_d = instr_break_addr[idx];
        `OFS_MASK:  rdata_d = instr_break_addr_mask[idx];
        `OFS_SPACE: rdata_d = {24'h000000, instr_break_space_id[idx]};
        `OFS_CTRL:  rdata_d = instr_break_ctrl[idx];
        default:    rdata_d = 32'h0000_0000;
      endcase
    end else if (bank_hit(reg_addr, `OFS_DATA_BASE, NUM_D, idx, fld)) begin
      case (fld)
        `OFS_ADDR:  rdata_d = data_break_addr[idx];
        `OFS_MASK:  rdata_d = data_break_addr_mask[idx];
        `OFS_SPACE: rdata_d = {24'h000000, data_break_space_id[idx]};
        `OFS_CTRL:  rdata_d = data_break_ctrl[idx];
        `OFS_VALUE: rdata_d = data_break_value[idx];
        default:    rdata_d = 32'h0000_0000;
      endcase
    end
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 32'h0000_0000;
    end else begin
      reg_rdata <= reg_read ? rdata_d : 32'h0000_0000;
    end
  end

  // results registered into the next stage together with the instruction
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      instr_break_exc <= 1'b0;
      instr_trigger   <= 1'b0;
      data_break_exc  <= 1'b0;
      data_trigger    <= 1'b0;
      store_block     <= 1'b0;
    end else begin
      logic de;
      de = 1'b0;
      for (int j = 0; j < 2; j++) begin
        de = de | (data_hit[j] && data_break_ctrl[j][`CTRL_EXC_BIT]);
      end
      instr_break_exc <= |(instr_hit & {instr_break_ctrl[3][`CTRL_EXC_BIT], instr_break_ctrl[2][`CTRL_EXC_BIT],
                                       instr_break_ctrl[1][`CTRL_EXC_BIT], instr_break_ctrl[0][`CTRL_EXC_BIT]});
      instr_trigger   <= |(instr_hit & {instr_break_ctrl[3][`CTRL_TRIG_BIT], instr_break_ctrl[2][`CTRL_TRIG_BIT],
                                       instr_break_ctrl[1][`CTRL_TRIG_BIT], instr_break_ctrl[0][`CTRL_TRIG_BIT]});
      data_break_exc  <= de;
      data_trigger    <= |(data_hit & {data_break_ctrl[1][`CTRL_TRIG_BIT], data_break_ctrl[0][`CTRL_TRIG_BIT]});
      store_block     <= de && data_is_store;
    end
  end

  // assertions on the core clock, held off until the reset copy is released

  // breakpoint 0 hits with the exception enabled, instruction and store
  sequence s_instr0_exc;
    instr_hit[0] && instr_break_ctrl[0][`CTRL_EXC_BIT];
  endsequence : s_instr0_exc

  sequence s_data0_exc_store;
    data_hit[0] && data_break_ctrl[0][`CTRL_EXC_BIT] && data_is_store;
  endsequence : s_data0_exc_store

  AST_NO_HIT_IN_DEBUG: assert property (@(posedge clk) disable iff (!rst_n)
    debug_mode
    |-> (instr_hit == 4'h0) && (data_hit == 2'h0))
    else $error("hit during debug mode");

  AST_FLAG_STICKY: assert property (@(posedge clk) disable iff (!rst_n)
    (instr_hit_flags_q[0] && !(reg_write && reg_addr == `OFS_INSTR_STATUS))
    |=> instr_hit_flags_q[0])
    else $error("status flag dropped by hardware");

  AST_DATA_FLAG_STICKY: assert property (@(posedge clk) disable iff (!rst_n)
    (data_hit_flags_q[1] && !(reg_write && reg_addr == `OFS_DATA_STATUS))
    |=> data_hit_flags_q[1])
    else $error("data status flag dropped by hardware");

  AST_FLAG_SET: assert property (@(posedge clk) disable iff (!rst_n)
    data_hit[0]
    |=> data_hit_flags_q[0])
    else $error("data hit did not set flag");

  AST_INSTR_FLAG_SET: assert property (@(posedge clk) disable iff (!rst_n)
    instr_hit[3]
    |=> instr_hit_flags_q[3])
    else $error("instruction hit did not set flag");

  AST_SPEC_IGNORED: assert property (@(posedge clk) disable iff (!rst_n)
    instr_speculative
    |-> instr_hit == 4'h0)
    else $error("speculative instruction compared");

  AST_UNALIGNED_IGNORED: assert property (@(posedge clk) disable iff (!rst_n)
    !instr_aligned
    |-> instr_hit == 4'h0)
    else $error("unaligned address compared");

  AST_HINT_IGNORED: assert property (@(posedge clk) disable iff (!rst_n)
    !data_explicit
    |-> data_hit == 2'h0)
    else $error("non-explicit transaction compared");

  AST_EXC_SAME_STAGE: assert property (@(posedge clk) disable iff (!rst_n)
    s_instr0_exc
    |=> instr_break_exc)
    else $error("exception late");

  AST_NO_INSTR_EXC_NO_HIT: assert property (@(posedge clk) disable iff (!rst_n)
    (instr_hit == 4'h0)
    |=> !instr_break_exc && !instr_trigger)
    else $error("instruction result without hit");

  AST_INSTR_TRIG: assert property (@(posedge clk) disable iff (!rst_n)
    (instr_hit[3] && instr_break_ctrl[3][`CTRL_TRIG_BIT])
    |=> instr_trigger)
    else $error("instruction trigger missing");

  AST_DATA_TRIG: assert property (@(posedge clk) disable iff (!rst_n)
    (data_hit[1] && data_break_ctrl[1][`CTRL_TRIG_BIT])
    |=> data_trigger)
    else $error("data trigger missing");

  AST_STORE_BLOCK: assert property (@(posedge clk) disable iff (!rst_n)
    s_data0_exc_store
    |=> store_block && data_break_exc)
    else $error("store not blocked");

  AST_LOAD_NOT_BLOCKED: assert property (@(posedge clk) disable iff (!rst_n)
    !data_is_store
    |=> !store_block)
    else $error("non-store blocked");

  AST_NO_EXC_NO_HIT: assert property (@(posedge clk) disable iff (!rst_n)
    (data_hit == 2'h0)
    |=> !data_break_exc)
    else $error("data exception without hit");

  AST_SKIP_LOAD: assert property (@(posedge clk) disable iff (!rst_n)
    (data_is_load && !data_is_store && data_break_ctrl[0][`CTRL_SKIP_LOAD_BIT])
    |-> !data_hit[0])
    else $error("skipped load matched");

  AST_IGNORED_LANES: assert property (@(posedge clk) disable iff (!rst_n)
    ((~data_break_ctrl[0][`CTRL_IGNORE_LO +: 4] & accessed_lanes) == 4'h0)
    |-> !data_hit[0])
    else $error("hit with every accessed lane ignored");

  AST_LANE1_VALUE: assert property (@(posedge clk) disable iff (!rst_n)
    (accessed_lanes[1] && !data_break_ctrl[0][`CTRL_IGNORE_LO + 1] && !data_break_ctrl[0][`CTRL_VMASK_LO + 1] &&
     (data_bus[15:8] != data_break_value[0][15:8]))
    |-> !data_hit[0])
    else $error("hit with lane 1 value differing");
endmodule : hw_break_match

// ### tb/core_pipe_model.sv
// behavioural model of the core pipeline and load/store unit feeding the breakpoint unit
module core_pipe_model (
  input  wire logic        clk,
  output logic             debug_mode,
  output logic      [7:0]  address_space_id,
  output logic             instr_valid,
  output logic             instr_speculative,
  output logic             instr_aligned,
  output logic      [31:0] instr_pc,
  output logic             data_valid,
  output logic             data_is_load,
  output logic             data_is_store,
  output logic             data_explicit,
  output logic      [31:0] data_addr,
  output logic      [3:0]  accessed_lanes,
  output logic      [31:0] data_bus
);
  timeunit 1ns;
  timeprecision 1ps;

  // quiet pipeline at time zero
  initial begin
    {debug_mode, address_space_id, instr_valid, instr_speculative, instr_aligned, instr_pc} = '0;
    {data_valid, data_is_load, data_is_store, data_explicit, data_addr, accessed_lanes, data_bus} = '0;
  end

  // core mode and current space id change right after an edge
  task automatic set_state(input logic dbg, input logic [7:0] sid);
    @(posedge clk);
    debug_mode       <= dbg;
    address_space_id <= sid;
  endtask : set_state

  // one executed instruction for one cycle; the pc then shows a changed value, not the last one
  task automatic exec_instr(input logic [31:0] pc, input logic spec, input logic al);
    @(posedge clk);
    instr_valid       <= 1'b1;
    instr_speculative <= spec;
    instr_aligned     <= al;
    instr_pc          <= pc;
    @(posedge clk);
    instr_valid       <= 1'b0;
    instr_pc          <= ~pc;
  endtask : exec_instr

  // one data transaction for one cycle; released lines show the inverse afterwards
  task automatic exec_data(input logic ld, input logic st, input logic ex, input logic [31:0] a,
                           input logic [3:0] ln, input logic [31:0] d);
    @(posedge clk);
    data_valid     <= 1'b1;
    data_is_load   <= ld;
    data_is_store  <= st;
    data_explicit  <= ex;
    data_addr      <= a;
    accessed_lanes <= ln;
    data_bus       <= d;
    @(posedge clk);
    data_valid     <= 1'b0;
    data_addr      <= ~a;
    accessed_lanes <= ~ln;
    data_bus       <= ~d;
  endtask : exec_data
endmodule : core_pipe_model

// ### tb/hw_break_match_tb.sv
// self-checking bench for the breakpoint unit: register tasks plus instruction and data scenarios
`include "hw_break_defs.svh"
`define CHK(what, exp, got) begin cmp_count++; if ((got) !== (exp)) begin n_mismatch++; \
  $display("BAD %s expected %h seen %h", what, exp, got); end end
module hw_break_match_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, reset_n, reg_write, reg_read;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata, reg_rdata;
  logic        debug_mode, instr_valid, instr_speculative, instr_aligned;
  logic [7:0]  address_space_id;
  logic [31:0] instr_pc, data_addr, data_bus;
  logic        data_valid, data_is_load, data_is_store, data_explicit;
  logic [3:0]  accessed_lanes;
  logic        instr_break_exc, instr_trigger, data_break_exc, data_trigger, store_block;
  int          n_mismatch;
  int          cmp_count;
  localparam logic [31:0] DA = 32'h2000_0010;

  hw_break_match #(.CONFIG(hw_break_pkg::CFG_FULL)) i_dut (.clk(clk), .reset_n(reset_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .debug_mode(debug_mode), .address_space_id(address_space_id), .instr_valid(instr_valid),
    .instr_speculative(instr_speculative), .instr_aligned(instr_aligned), .instr_pc(instr_pc),
    .data_valid(data_valid), .data_is_load(data_is_load), .data_is_store(data_is_store),
    .data_explicit(data_explicit), .data_addr(data_addr), .accessed_lanes(accessed_lanes), .data_bus(data_bus),
    .instr_break_exc(instr_break_exc), .instr_trigger(instr_trigger), .data_break_exc(data_break_exc),
    .data_trigger(data_trigger), .store_block(store_block));

  core_pipe_model i_core (.clk(clk), .debug_mode(debug_mode), .address_space_id(address_space_id),
    .instr_valid(instr_valid), .instr_speculative(instr_speculative), .instr_aligned(instr_aligned),
    .instr_pc(instr_pc), .data_valid(data_valid), .data_is_load(data_is_load), .data_is_store(data_is_store),
    .data_explicit(data_explicit), .data_addr(data_addr), .accessed_lanes(accessed_lanes), .data_bus(data_bus));

  // clock at 40 MHz
  initial clk = 1'b0;
  always #12.5 clk = ~clk;

  // register offsets of breakpoint n, word k, in the instruction and data banks
  function automatic logic [7:0] ib(input int n, input int k);
    return 8'(`OFS_INSTR_BASE + n * `OFS_STRIDE + k * 4);
  endfunction : ib
  function automatic logic [7:0] db(input int n, input int k);
    return 8'(`OFS_DATA_BASE + n * `OFS_STRIDE + k * 4);
  endfunction : db

  // one-cycle write strobe
  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_write <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_write <= 1'b0;
  endtask : reg_wr

  // one-cycle read strobe, data taken in the following cycle
  task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    reg_read <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_read <= 1'b0;
    #1;
    `CHK(what, exp, reg_rdata)
  endtask : rd_chk

  // run one instruction and check the result pulse in the next cycle
  task automatic ichk(input logic [31:0] pc, input logic spec, input logic al, input logic e_exc, input logic e_trg);
    i_core.exec_instr(pc, spec, al);
    #1;
    `CHK("instr_break_exc", e_exc, instr_break_exc)
    `CHK("instr_trigger", e_trg, instr_trigger)
  endtask : ichk

  // run one data transaction and check exception, trigger and store blocking
  task automatic dchk(input logic ld, input logic st, input logic ex, input logic [31:0] a, input logic [3:0] ln,
                      input logic [31:0] d, input logic e_exc, input logic e_trg, input logic e_blk);
    i_core.exec_data(ld, st, ex, a, ln, d);
    #1;
    `CHK("data_break_exc", e_exc, data_break_exc)
    `CHK("data_trigger", e_trg, data_trigger)
    `CHK("store_block", e_blk, store_block)
  endtask : dchk

  // verdict and end of run
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : end_sim

  // watchdog against a hang
  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    end_sim();
  end

  // main sequence
  initial begin
    {reset_n, reg_write, reg_read, reg_addr, reg_wdata} = '0;
    n_mismatch = 0;
    cmp_count  = 0;
    repeat (6) @(posedge clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge clk);
    rd_chk("ictrl0 reset", ib(0, 3), `CTRL_RESET);
    rd_chk("dmask1 reset", db(1, 1), `MASK_RESET);
    rd_chk("unmapped", 8'h3C, 32'h0000_0000);
    // instruction breakpoint 0, exception only, low four pc bits masked
    reg_wr(ib(0, 0), 32'h1000_0040);
    reg_wr(ib(0, 1), 32'h0000_000F);
    reg_wr(ib(0, 3), 32'h0000_0001);
    rd_chk("iaddr0", ib(0, 0), 32'h1000_0040);
    ichk(32'h1000_004C, 1'b0, 1'b1, 1'b1, 1'b0);
    ichk(32'h1000_0050, 1'b0, 1'b1, 1'b0, 1'b0);
    ichk(32'h1000_0044, 1'b1, 1'b1, 1'b0, 1'b0);
    ichk(32'h1000_0046, 1'b0, 1'b0, 1'b0, 1'b0);
    i_core.set_state(1'b1, 8'h00);
    ichk(32'h1000_0044, 1'b0, 1'b1, 1'b0, 1'b0);
    i_core.set_state(1'b0, 8'h00);
    rd_chk("instr status", `OFS_INSTR_STATUS, 32'h0000_0001);
    reg_wr(`OFS_INSTR_STATUS, 32'h0000_0001);
    rd_chk("instr status cleared", `OFS_INSTR_STATUS, 32'h0000_0000);
    // breakpoint 3, trigger only, with space id compare on purpose
    reg_wr(ib(3, 0), 32'h0000_2000);
    reg_wr(ib(3, 2), 32'h0000_0005);
    reg_wr(ib(3, 3), 32'h0000_0006);
    i_core.set_state(1'b0, 8'h06);
    ichk(32'h0000_2000, 1'b0, 1'b1, 1'b0, 1'b0);
    i_core.set_state(1'b0, 8'h05);
    ichk(32'h0000_2000, 1'b0, 1'b1, 1'b0, 1'b1);
    rd_chk("instr status bp3", `OFS_INSTR_STATUS, 32'h0000_0008);
    i_core.set_state(1'b0, 8'h00);
    // data breakpoint 0, exception, value held in raw bus byte order
    reg_wr(db(0, 0), DA);
    reg_wr(db(0, 4), 32'h4433_2211);
    reg_wr(db(0, 3), 32'h0000_0001);
    dchk(1'b0, 1'b1, 1'b1, DA, 4'h3, 32'hAAAA_2211, 1'b1, 1'b0, 1'b1);
    dchk(1'b0, 1'b1, 1'b1, DA, 4'h3, 32'hAAAA_2311, 1'b0, 1'b0, 1'b0);
    dchk(1'b1, 1'b0, 1'b1, DA, 4'h3, 32'h0000_2211, 1'b1, 1'b0, 1'b0);
    dchk(1'b1, 1'b0, 1'b0, DA, 4'h3, 32'h0000_2211, 1'b0, 1'b0, 1'b0);
    dchk(1'b0, 1'b1, 1'b1, DA + 32'h4, 4'h3, 32'h0000_2211, 1'b0, 1'b0, 1'b0);
    rd_chk("data status", `OFS_DATA_STATUS, 32'h0000_0001);
    // lanes 1:0 ignored, loads skipped
    reg_wr(db(0, 3), 32'h0000_0309);
    dchk(1'b0, 1'b1, 1'b1, DA, 4'h3, 32'hAAAA_2211, 1'b0, 1'b0, 1'b0);
    dchk(1'b0, 1'b1, 1'b1, DA, 4'h4, 32'hAA33_BBBB, 1'b1, 1'b0, 1'b1);
    dchk(1'b1, 1'b0, 1'b1, DA, 4'h4, 32'hAA33_BBBB, 1'b0, 1'b0, 1'b0);
    // every lane value-masked, stores skipped
    reg_wr(db(0, 3), 32'h0000_F011);
    dchk(1'b1, 1'b0, 1'b1, DA, 4'hF, 32'h0000_0000, 1'b1, 1'b0, 1'b0);
    dchk(1'b0, 1'b1, 1'b1, DA, 4'hF, 32'h0000_0000, 1'b0, 1'b0, 1'b0);
    // data breakpoint 1 as trigger only
    reg_wr(db(1, 0), 32'h3000_0000);
    reg_wr(db(1, 3), 32'h0000_F002);
    i_core.set_state(1'b1, 8'h00);
    dchk(1'b0, 1'b1, 1'b1, 32'h3000_0000, 4'hF, 32'h0, 1'b0, 1'b0, 1'b0);
    i_core.set_state(1'b0, 8'h00);
    dchk(1'b0, 1'b1, 1'b1, 32'h3000_0000, 4'hF, 32'h0, 1'b0, 1'b1, 1'b0);
    rd_chk("data status both", `OFS_DATA_STATUS, 32'h0000_0003);
    end_sim();
  end
endmodule : hw_break_match_tb
